// ===== hdl/bgm_top.sv
// Battery gas gauge and voltage monitor digital control
`timescale 1ns/100ps
`default_nettype none
`include "bgm_regs.svh"

module bgm_top (
    input  wire logic                      clk_sys_in,          // 100 MHz system clock
    input  wire logic                      rst_in,              // Power-up reset, sync high
    input  wire logic                      clk_32k_in,          // Slow converter clock pin
    input  wire logic                      gauge_bit_in,        // Gauge modulator bit
    input  wire logic                      volt_bit_in,         // Monitor modulator bit
    input  wire logic                      standby_pin_in,      // Low stops the gauge
    input  wire logic                      reset_pin_low_in,    // Active low reset pin
    input  wire logic                      por_low_in,          // Low while battery < POR
    input  wire logic                      gg_wr_in,            // Gauge control write pulse
    input  wire bgm_pkg::bgm_gg_ctrl_t     gg_ctrl_in,          // Gauge control word
    input  wire logic                      vm_wr_in,            // Monitor control write pulse
    input  wire bgm_pkg::bgm_vm_ctrl_t     vm_ctrl_in,          // Monitor control word
    output logic                           gauge_short_out,     // Short the gauge inputs
    output logic                           volt_gnd_out,        // Ground monitor input
    output bgm_pkg::bgm_gg_stat_t          gg_stat_out,         // Gauge status bits
    output logic [`BGM_GG_RES_W-1:0]       gauge_result_out,    // Latest gauge result
    output logic [`BGM_ACC_W-1:0]          charge_snap_out,     // Charge snapshot
    output logic [`BGM_ACC_W-1:0]          discharge_snap_out,  // Discharge snapshot
    output logic [`BGM_CNT_W-1:0]          conv_count_out,      // Counter snapshot
    output bgm_pkg::bgm_vm_stat_t          vm_stat_out,         // Monitor status bits
    output logic [`BGM_VM_RES_W-1:0]       volt_result_out      // Latest monitor result
);
    import bgm_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    bgm_state_t state_q;      // All flops of the block
    bgm_state_t state_d;      // Next value
    logic       tick;         // One cycle per slow-clock rising edge
    logic       standby_ok;   // Standby pin high after sync
    logic       pins_live;    // Neither reset pin nor low battery
    logic       gg_end;       // Gauge conversion finishes this tick
    logic       vm_end;       // Monitor conversion finishes this tick
    logic [12:0] vm_last;     // Final tick index of monitor conversion

    // Halve a modulator ones count and saturate it to a result width
    function automatic logic [11:0] sat_half(input logic [13:0] ones,
                                             input logic [11:0] max);
        logic [13:0] half;
        half = {1'b0, ones[13:1]};
        if (half > {2'h0, max}) begin
            sat_half = max;
        end else begin
            sat_half = half[11:0];
        end
    endfunction

    // ------------------------------------------------------------------
    // Decodes from the registered state
    // ------------------------------------------------------------------
    // Only the second flop of each synchroniser is looked at
    assign tick       = state_q.sync2[`BGM_PIN_CLK32] & ~state_q.k32_prev;
    assign standby_ok = state_q.sync2[`BGM_PIN_STANDBY_PIN];
    assign pins_live  = state_q.sync2[`BGM_PIN_RSTN] & state_q.sync2[`BGM_PIN_PORN];
    assign gg_end     = tick & state_q.gg.gauge_running
                        & (state_q.gg_tcnt == 13'(`BGM_GG_CONV_TICKS - 1));
    assign vm_last    = state_q.vm.volt_monitor_resolution
                        ? 13'(`BGM_VM_HI_TICKS - 1)
                        : 13'(`BGM_VM_LO_TICKS - 1);
    assign vm_end     = tick & state_q.vm.volt_monitor_running
                        & (state_q.vm_tcnt == vm_last);

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    // Hardware clears are applied before host writes so a set arriving
    // in the same cycle as a self-clear is never lost.
    always_comb begin
        logic [13:0] signed_res;
        logic [12:0] gg_res;
        logic [13:0] gg_all;      // Gauge ones count including this tick's bit
        logic [13:0] vm_all;      // Monitor ones count including this tick's bit
        signed_res = 14'h0;
        gg_res     = 13'h0;
        gg_all     = 14'h0;
        vm_all     = 14'h0;
        state_d    = state_q;

        // Pin synchronisers, two flops each
        state_d.sync1    = {por_low_in, reset_pin_low_in, standby_pin_in,
                            volt_bit_in, gauge_bit_in, clk_32k_in};
        state_d.sync2    = state_q.sync1;
        state_d.k32_prev = state_q.sync2[`BGM_PIN_CLK32];

        // Ones counts take in the bit of the closing tick as well, so that
        // every conversion weighs all of its samples, the last one too
        gg_all = state_q.gg_ones + {13'h0, state_q.sync2[`BGM_PIN_GG_BIT]};
        vm_all = state_q.vm_ones + {13'h0, state_q.sync2[`BGM_PIN_VM_BIT]};

        // Gauge result: ones count centred on mid scale, clamped
        signed_res = gg_all - `BGM_GG_MID;
        if (gg_all == 14'(`BGM_GG_CONV_TICKS)) begin
            gg_res = 13'h0fff;
        end else begin
            gg_res = signed_res[12:0];
        end

        // Gauge converter on each slow tick
        if (tick) begin
            if (state_q.gg.gauge_running) begin
                state_d.gg_tcnt = state_q.gg_tcnt + 13'h1;
                state_d.gg_ones = state_q.gg_ones + {13'h0, state_q.sync2[`BGM_PIN_GG_BIT]};
                if (gg_end) begin
                    state_d.gg_result = gg_res;
                    if (gg_res[12]) begin
                        // Wraps modulo 2^24 by width
                        state_d.dis = state_q.dis + `BGM_ACC_W'(-$signed(gg_res));
                    end else begin
                        state_d.chg = state_q.chg + {11'h0, gg_res};
                    end
                    state_d.nconv   = state_q.nconv + 12'h1;
                    state_d.gg_tcnt = 13'h0;
                    state_d.gg_ones = 14'h0;
                    // Enable off only takes effect here, between conversions
                    state_d.gg.gauge_running = state_q.gg.gauge_enable;
                end
            end else if (state_q.gg.gauge_enable && standby_ok) begin
                state_d.gg.gauge_running = 1'b1;
                state_d.gg_tcnt          = 13'h0;
                state_d.gg_ones          = 14'h0;
            end

            // Snapshot uses pre-clear values so a paired clear lands after it
            if (state_q.gg.rd_req) begin
                state_d.chg_snap   = state_q.chg;
                state_d.dis_snap   = state_q.dis;
                state_d.nconv_snap = state_q.nconv;
                state_d.gg.rd_req  = 1'b0;
            end
            if (state_q.gg.clear_charge_acc) begin
                state_d.chg                 = `BGM_ACC_RESET;
                state_d.gg.clear_charge_acc = 1'b0;
            end
            if (state_q.gg.clear_discharge_acc) begin
                state_d.dis                    = `BGM_ACC_RESET;
                state_d.gg.clear_discharge_acc = 1'b0;
            end
            if (state_q.gg.clear_counter) begin
                state_d.nconv            = `BGM_CNT_RESET;
                state_d.gg.clear_counter = 1'b0;
            end
        end

        // Standby low abandons a conversion without waiting
        if (!standby_ok) begin
            state_d.gg.gauge_running = 1'b0;
            state_d.gg_tcnt          = 13'h0;
            state_d.gg_ones          = 14'h0;
        end

        // Monitor warm-up and conversion on slow ticks
        if (tick) begin
            if (!state_q.vm.volt_monitor_power) begin
                state_d.vm.volt_monitor_ready = 1'b0;
                state_d.vm_warm               = 2'h0;
            end else if (!state_q.vm.volt_monitor_ready) begin
                state_d.vm_warm = state_q.vm_warm + 2'h1;
                if (state_q.vm_warm == 2'(`BGM_VM_WARM_TICKS - 1)) begin
                    state_d.vm.volt_monitor_ready = 1'b1;
                end
            end
            if (state_q.vm.volt_monitor_running) begin
                state_d.vm_tcnt = state_q.vm_tcnt + 13'h1;
                state_d.vm_ones = state_q.vm_ones + {13'h0, state_q.sync2[`BGM_PIN_VM_BIT]};
                if (vm_end) begin
                    // Result is stored in the same edge that drops running
                    if (state_q.vm.volt_monitor_resolution) begin
                        state_d.vm_result = sat_half(vm_all, 12'hfff);
                    end else begin
                        state_d.vm_result = sat_half(vm_all, 12'h07f);
                    end
                    state_d.vm.volt_monitor_running = 1'b0;
                end
            end
        end

        // Start is held exactly one clock then dropped
        state_d.vm.volt_monitor_start = 1'b0;
        if (state_q.vm.volt_monitor_start && state_q.vm.volt_monitor_ready
            && !state_q.vm.volt_monitor_running) begin
            state_d.vm.volt_monitor_running = 1'b1;
            state_d.vm_tcnt                 = 13'h0;
            state_d.vm_ones                 = 14'h0;
        end
        if (!state_q.vm.volt_monitor_power) begin
            state_d.vm.volt_monitor_running = 1'b0;
        end

        // Host writes; pending bits are only ever set here
        if (gg_wr_in) begin
            state_d.gg.gauge_enable     = gg_ctrl_in.gauge_enable;
            state_d.gg.gauge_offset_cal = gg_ctrl_in.gauge_offset_cal;
            state_d.gg.rd_req           = state_d.gg.rd_req | gg_ctrl_in.rd_req;
            state_d.gg.clear_charge_acc = state_d.gg.clear_charge_acc
                                          | gg_ctrl_in.clear_charge_acc;
            state_d.gg.clear_discharge_acc = state_d.gg.clear_discharge_acc
                                             | gg_ctrl_in.clear_discharge_acc;
            state_d.gg.clear_counter    = state_d.gg.clear_counter | gg_ctrl_in.clear_counter;
        end
        if (vm_wr_in) begin
            state_d.vm.volt_monitor_power      = vm_ctrl_in.volt_monitor_power;
            state_d.vm.volt_monitor_resolution = vm_ctrl_in.volt_monitor_resolution;
            state_d.vm.volt_monitor_offset_cal = vm_ctrl_in.volt_monitor_offset_cal;
            state_d.vm.volt_monitor_start      = vm_ctrl_in.volt_monitor_start;
        end

        // Reset pin or low battery: control back to power-up values,
        // accumulators and counter deliberately kept
        if (!pins_live) begin
            state_d.gg      = '0;
            state_d.gg_tcnt = 13'h0;
            state_d.gg_ones = 14'h0;
            state_d.vm      = '0;
            state_d.vm_warm = 2'h0;
            state_d.vm_tcnt = 13'h0;
            state_d.vm_ones = 14'h0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from flops
    // ------------------------------------------------------------------
    assign gauge_short_out    = state_q.gg.gauge_offset_cal;
    assign volt_gnd_out       = state_q.vm.volt_monitor_offset_cal;
    assign gg_stat_out        = state_q.gg;
    assign gauge_result_out   = state_q.gg_result;
    assign charge_snap_out    = state_q.chg_snap;
    assign discharge_snap_out = state_q.dis_snap;
    assign conv_count_out     = state_q.nconv_snap;
    assign vm_stat_out        = state_q.vm;
    assign volt_result_out    = state_q.vm_result;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    // Slow ticks seen while a read request waits
    logic [3:0] rd_wait_q;
    always_ff @(posedge clk_sys_in) begin
        if (rst_in || !state_q.gg.rd_req) begin
            rd_wait_q <= 4'h0;
        end else if (tick && rd_wait_q != 4'hf) begin
            rd_wait_q <= rd_wait_q + 4'h1;
        end
    end

    // Sign of the result that closes on this tick, for the accumulator checks
    function automatic logic gg_res_neg();
        gg_res_neg = ((state_q.gg_ones + {13'h0, state_q.sync2[`BGM_PIN_GG_BIT]})
                      < `BGM_GG_MID);
    endfunction

    sequence s_pair_clear;
        tick && state_q.gg.rd_req && state_q.gg.clear_charge_acc && pins_live;
    endsequence
    sequence s_copy_then_zero;
        state_q.chg_snap == $past(state_q.chg) && state_q.chg == `BGM_ACC_RESET;
    endsequence

    charge_add_a: assert property (
        gg_end && !gg_res_neg() && !state_q.gg.clear_charge_acc && pins_live
        |=> state_q.chg == $past(state_q.chg) + {11'h0, state_q.gg_result})
        else $error("charge accumulator not advanced by result");
    conv_count_a: assert property (gg_end && !state_q.gg.clear_counter && pins_live
        |=> state_q.nconv == $past(state_q.nconv) + 12'h1)
        else $error("conversion counter not advanced");
    snap_bound_a: assert property (rd_wait_q <= 4'(`BGM_SNAP_MAX_TICKS))
        else $error("read request pending too long");
    copy_first_a: assert property (s_pair_clear |=> s_copy_then_zero)
        else $error("clear overtook snapshot");
    clear_drop_a: assert property (tick && state_q.gg.clear_counter && !gg_wr_in
        |=> !state_q.gg.clear_counter)
        else $error("counter clear bit stuck");
    pin_disable_a: assert property (!pins_live |=> !state_q.gg.gauge_enable
        && !state_q.gg.gauge_running && !state_q.vm.volt_monitor_power)
        else $error("reset pin did not disable");
    standby_stop_a: assert property (!standby_ok |=> !state_q.gg.gauge_running)
        else $error("standby did not stop gauge");
    start_pulse_a: assert property (state_q.vm.volt_monitor_start && !vm_wr_in
        |=> !state_q.vm.volt_monitor_start)
        else $error("start bit not self-cleared");
    // A powered monitor may only drop running on the tick that stores the result
    run_result_a: assert property ($fell(state_q.vm.volt_monitor_running) && pins_live
        && state_q.vm.volt_monitor_power |-> $past(vm_end))
        else $error("monitor running fell before its result");

    // Negative results grow the discharge side by their magnitude
    dis_add_a: assert property (
        gg_end && gg_res_neg() && !state_q.gg.clear_discharge_acc && pins_live
        |=> state_q.dis == $past(state_q.dis) - {{11{state_q.gg_result[12]}}, state_q.gg_result})
        else $error("discharge accumulator not advanced by result");
    rd_clear_a: assert property (tick && state_q.gg.rd_req && !gg_wr_in
        |=> !state_q.gg.rd_req)
        else $error("read request bit not self-cleared");
    enable_stop_a: assert property (gg_end && !state_q.gg.gauge_enable
        |=> !state_q.gg.gauge_running)
        else $error("gauge kept running after enable cleared");
    ready_rise_a: assert property (
        tick && pins_live && state_q.vm.volt_monitor_power && !state_q.vm.volt_monitor_ready
        && state_q.vm_warm == 2'(`BGM_VM_WARM_TICKS - 1) |=> state_q.vm.volt_monitor_ready)
        else $error("monitor ready flag not raised after warm-up");

endmodule
`default_nettype wire

// ===== hdl/bgm_regs.svh
// Constants for the battery gauge and voltage monitor control block
`ifndef BGM_REGS_SVH
`define BGM_REGS_SVH

// ------------------------------------------------------------------
// Pin synchroniser bit positions
// ------------------------------------------------------------------
`define BGM_PIN_CLK32      0
`define BGM_PIN_GG_BIT     1
`define BGM_PIN_VM_BIT     2
`define BGM_PIN_STANDBY_PIN      3
`define BGM_PIN_RSTN       4
`define BGM_PIN_PORN       5
`define BGM_PIN_COUNT      6

// ------------------------------------------------------------------
// Timing counts, in ticks of the 32.768 kHz clock
// ------------------------------------------------------------------
`define BGM_GG_CONV_TICKS  8192
`define BGM_VM_LO_TICKS    256
`define BGM_VM_HI_TICKS    8192
`define BGM_SNAP_MAX_TICKS 8
`define BGM_VM_WARM_TICKS  2

// ------------------------------------------------------------------
// Widths and power-up values
// ------------------------------------------------------------------
`define BGM_ACC_W          24
`define BGM_CNT_W          12
`define BGM_GG_RES_W       13
`define BGM_VM_RES_W       12
`define BGM_GG_MID         14'h1000
`define BGM_ACC_RESET      24'h000000
`define BGM_CNT_RESET      12'h000

`endif

// ===== hdl/bgm_pkg.sv
// Types shared by the battery gauge and voltage monitor control block
`include "bgm_regs.svh"

package bgm_pkg;

    // Host write to the gauge control bits
    typedef struct packed {
        logic gauge_enable;
        logic gauge_offset_cal;
        logic rd_req;
        logic clear_charge_acc;
        logic clear_discharge_acc;
        logic clear_counter;
    } bgm_gg_ctrl_t;

    // Host write to the volt_monitor_ctrl bits
    typedef struct packed {
        logic volt_monitor_power;
        logic volt_monitor_resolution;
        logic volt_monitor_offset_cal;
        logic volt_monitor_start;
    } bgm_vm_ctrl_t;

    // Gauge status seen by the host
    typedef struct packed {
        logic gauge_enable;
        logic gauge_offset_cal;
        logic gauge_running;
        logic rd_req;
        logic clear_charge_acc;
        logic clear_discharge_acc;
        logic clear_counter;
    } bgm_gg_stat_t;

    // Monitor status seen by the host
    typedef struct packed {
        logic volt_monitor_power;
        logic volt_monitor_resolution;
        logic volt_monitor_offset_cal;
        logic volt_monitor_start;
        logic volt_monitor_ready;
        logic volt_monitor_running;
    } bgm_vm_stat_t;

    // Whole state of the block
    typedef struct packed {
        logic [`BGM_PIN_COUNT-1:0] sync1;
        logic [`BGM_PIN_COUNT-1:0] sync2;
        logic                      k32_prev;
        bgm_gg_stat_t              gg;
        logic [12:0]               gg_tcnt;
        logic [13:0]               gg_ones;
        logic [`BGM_GG_RES_W-1:0]  gg_result;
        logic [`BGM_ACC_W-1:0]     chg;
        logic [`BGM_ACC_W-1:0]     dis;
        logic [`BGM_CNT_W-1:0]     nconv;
        logic [`BGM_ACC_W-1:0]     chg_snap;
        logic [`BGM_ACC_W-1:0]     dis_snap;
        logic [`BGM_CNT_W-1:0]     nconv_snap;
        bgm_vm_stat_t              vm;
        logic [1:0]                vm_warm;
        logic [12:0]               vm_tcnt;
        logic [13:0]               vm_ones;
        logic [`BGM_VM_RES_W-1:0]  vm_result;
    } bgm_state_t;

endpackage

// ===== tb/bgm_front_model.sv
// Slow clock and modulator bit source facing the converter pins
`timescale 1ns/100ps
`default_nettype none
module bgm_front_model (
    input  wire logic clk_sys_in,     // System clock reference
    input  wire logic gauge_lvl_in,   // Level fed to the gauge modulator
    input  wire logic volt_lvl_in,    // Level fed to the monitor modulator
    output logic      clk_32k_out,    // Slow clock, six system cycles a period
    output logic      gauge_bit_out,  // Gauge modulator bit
    output logic      volt_bit_out    // Monitor modulator bit
);
    logic [2:0] ph_q = 3'h0;          // Phase within one slow period
    // Free running like the real RTC; sped up so that a whole conversion fits the run
    always_ff @(posedge clk_sys_in) begin
        ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
    end
    assign clk_32k_out   = (ph_q < 3'h3);
    assign gauge_bit_out = gauge_lvl_in;
    assign volt_bit_out  = volt_lvl_in;
endmodule
`default_nettype wire

// ===== tb/bgm_top_tb.sv
// Self-checking bench for the gauge and monitor control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAIT_FOR(c, n) begin k = 0; while (!(c) && k < (n)) begin \
    @(negedge clk_sys_in); k++; end if (!(c)) begin `CHK(1'b0, 1'b1) print_verdict(); end end
module bgm_top_tb;
    import bgm_pkg::*;
    logic clk_sys_in = 1'b0, rst_in = 1'b1, k32, gbit, vbit, glvl = 1'b0, vlvl = 1'b0;
    logic stby = 1'b1, rstn = 1'b1, porn = 1'b1, gg_wr = 1'b0, vm_wr = 1'b0, gcal, vcal;
    bgm_gg_ctrl_t gg_ctrl = 6'h00;   // Gauge control word
    bgm_vm_ctrl_t vm_ctrl = 4'h0;    // Monitor control word
    bgm_gg_stat_t gg_stat;
    bgm_vm_stat_t vm_stat;
    logic gshort, vgnd;
    logic [12:0] gres;
    logic [23:0] csnap, dsnap;
    logic [11:0] cnt, vres;
    int error_cnt = 0, n_checks = 0, k;
    initial forever #5 clk_sys_in = ~clk_sys_in;
    bgm_front_model fe (.clk_sys_in(clk_sys_in), .gauge_lvl_in(glvl), .volt_lvl_in(vlvl),
        .clk_32k_out(k32), .gauge_bit_out(gbit), .volt_bit_out(vbit));
    bgm_top dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .clk_32k_in(k32),
        .gauge_bit_in(gbit), .volt_bit_in(vbit), .standby_pin_in(stby),
        .reset_pin_low_in(rstn), .por_low_in(porn), .gg_wr_in(gg_wr), .gg_ctrl_in(gg_ctrl),
        .vm_wr_in(vm_wr), .vm_ctrl_in(vm_ctrl), .gauge_short_out(gshort), .volt_gnd_out(vgnd),
        .gg_stat_out(gg_stat), .gauge_result_out(gres), .charge_snap_out(csnap),
        .discharge_snap_out(dsnap), .conv_count_out(cnt), .vm_stat_out(vm_stat),
        .volt_result_out(vres));
    // One-cycle write pulses, driven on the falling edge
    task automatic gg_write(input logic [5:0] v);
        @(negedge clk_sys_in); gg_wr = 1'b1; gg_ctrl = v;
        @(negedge clk_sys_in); gg_wr = 1'b0;
    endtask
    task automatic vm_write(input logic [3:0] v);
        @(negedge clk_sys_in); vm_wr = 1'b1; vm_ctrl = v;
        @(negedge clk_sys_in); vm_wr = 1'b0;
    endtask
    // Whole gauge conversion: ones less 4096, clamped to the positive limit
    function automatic logic [12:0] gauge_exp(input logic lvl);
        int r;
        r = (lvl ? 8192 : 0) - 4096;
        if (r > 4095) r = 4095;
        return r[12:0];
    endfunction
    task automatic print_verdict();
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        k = $urandom(12);
        repeat (3) @(negedge clk_sys_in);
        rst_in = 1'b0;
        `CHK(gg_stat, 7'h00)
        `CHK(vm_stat, 6'h00)
        // Pin synchronisers must fill before a write can land
        repeat (3) @(negedge clk_sys_in);
        vlvl = $urandom % 2; vcal = $urandom % 2;
        // Start while powered down is dropped
        vm_write(4'h1);
        repeat (4) @(negedge clk_sys_in);
        `CHK(vm_stat.volt_monitor_running, 1'b0)
        vm_write({1'b1, 1'b0, vcal, 1'b0});
        `WAIT_FOR(vm_stat.volt_monitor_ready, 100)
        `CHK(vgnd, vcal)
        vm_write({1'b1, 1'b0, vcal, 1'b1});
        `WAIT_FOR(vm_stat.volt_monitor_running, 4)
        `CHK(vm_stat.volt_monitor_start, 1'b0)
        `WAIT_FOR(!vm_stat.volt_monitor_running, 2000)
        `CHK(k > 1525 && k < 1540, 1'b1)
        `CHK(vres, vlvl ? 12'h07f : 12'h000)
        // One gauge conversion, enable dropped in mid-run
        glvl = $urandom % 2; gcal = $urandom % 2;
        gg_write({1'b1, gcal, 4'h0});
        `WAIT_FOR(gg_stat.gauge_running, 20)
        `CHK(gshort, gcal)
        gg_write({1'b0, gcal, 4'h0});
        // A 12-bit monitor conversion runs alongside the gauge one
        vm_write({1'b1, 1'b1, vcal, 1'b1});
        `WAIT_FOR(!gg_stat.gauge_running, 60000)
        `CHK(k > 49130 && k < 49160, 1'b1)
        `CHK(gres, gauge_exp(glvl))
        `WAIT_FOR(!vm_stat.volt_monitor_running, 100)
        `CHK(vres, vlvl ? 12'hfff : 12'h000)
        // Pin reset pulse clears control but keeps results and accumulators
        rstn = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        rstn = 1'b1;
        repeat (4) @(negedge clk_sys_in);
        `CHK(vm_stat, 6'h00)
        `CHK(gres, gauge_exp(glvl))
        // Snapshot together with all three clears; host waits for the copy
        gg_write(6'h0f);
        `WAIT_FOR(gg_stat[3:0] == 4'h0, 60)
        `CHK(csnap, glvl ? 24'h000fff : 24'h000000)
        `CHK(dsnap, glvl ? 24'h000000 : 24'h001000)
        `CHK(cnt, 12'h001)
        gg_write(6'h08);
        `WAIT_FOR(!gg_stat.rd_req, 60)
        `CHK({csnap, dsnap, cnt}, 60'h0)
        // Standby abandons a running conversion at once
        gg_write(6'h20);
        `WAIT_FOR(gg_stat.gauge_running, 20)
        stby = 1'b0;
        `WAIT_FOR(!gg_stat.gauge_running, 5)
        stby = 1'b1;
        gg_write(6'h08);
        `WAIT_FOR(!gg_stat.rd_req, 60)
        `CHK(cnt, 12'h000)
        // Pin reset or low battery drops both enables
        gg_write(6'h20);
        vm_write(4'h8);
        if ($urandom % 2) rstn = 1'b0;
        else porn = 1'b0;
        repeat (5) @(negedge clk_sys_in);
        `CHK(gg_stat.gauge_enable, 1'b0)
        `CHK(vm_stat.volt_monitor_power, 1'b0)
        print_verdict();
    end
endmodule
`default_nettype wire
